// ===== rtl/ipwc_irq_ctrl.sv
// Function
// - Taking an enabled request redirects the core to its vector address.
// - Vectors 0003,000B,0013,001B, shared 0023 serial, shared 002B timer 2.
// - Vectors 0043,004B, shared 0053 SPI, 005B,0063,006B.
// - Each source is detected by its own level or edge polarity.
// - Low enable register: bit 7 global gate, bits 5..0 per source.
// - High enable register bits 7,5..0 enable the newer sources.
// - SPI completions share a line, gated by master bit 1, slave bit 0.
// - Group level is high bit and low bit together, 11 highest.
// - Sources share priority by six fixed groups.
// - Request flag register holds eight flags at fixed bits.
// - Wake, USB, USB wake, SPI, radio flags clear on vectoring.
// - Wake field 00 needs enable, 10 always wakes, 11 ignores.
// - Wake fields govern radio, internal wake, USB, USB wake.
// - A waking source sets its flag even when disabled.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "ipwc_params.svh"
module ipwc_irq_ctrl
  import ipwc_pkg::*;
(
  input wire logic pclk, // Processor clock
  input wire logic presetn, // Async system reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic p03_pin_n, // Pin P0.3 request, active low
  input wire logic p04_pin_n, // Pin P0.4 request, active low
  input wire logic crypto_ready_request_n, // Crypto ready, active low
  input wire logic timer0_overflow_flag, // Timer 0 flag
  input wire logic timer1_overflow_flag, // Timer 1 flag
  input wire logic timer2_overflow_flag, // Timer 2 overflow
  input wire logic timer2_reload_flag, // Timer 2 external event
  input wire logic serial_rx_done, // Serial receive flag
  input wire logic serial_tx_done, // Serial transmit flag
  input wire logic radio_spi_ready, // Radio SPI ready
  input wire logic radio_request, // Radio request line
  input wire logic master_spi_complete, // Master SPI done line
  input wire logic slave_spi_complete, // Slave SPI done line
  input wire logic usb_request, // USB request line
  input wire logic usb_wake_request, // USB wakeup line
  input wire logic internal_wake_request, // Internal wakeup line
  output logic irq_req, // Request to core
  output logic [15:0] irq_vector, // Vector for irq_req
  input wire logic irq_ack, // Core takes the request
  input wire logic irq_return, // Core leaves a service routine
  input wire logic cpu_standby, // Core clock is stopped
  output logic cpu_wake // Pulse: restart the core clock
);

  ////////////////////////////////////////////////////////////////////////
  // Source table; index order is group order then table order

  localparam logic [2*`IPWC_NUM_LINES-1:0] DET_MODES = {
    IPWC_DET_BOTH, // 15 slave SPI
    IPWC_DET_FALL, // 14 crypto
    IPWC_DET_RISE, // 13 internal wake
    IPWC_DET_HIGH, // 12 timer 2 reload
    IPWC_DET_HIGH, // 11 timer 2 overflow
    IPWC_DET_RISE, // 10 USB
    IPWC_DET_HIGH, // 9 serial tx
    IPWC_DET_HIGH, // 8 serial rx
    IPWC_DET_RISE, // 7 USB wake
    IPWC_DET_HIGH, // 6 timer 1
    IPWC_DET_BOTH, // 5 master SPI
    IPWC_DET_FALL, // 4 P0.4
    IPWC_DET_HIGH, // 3 radio SPI ready
    IPWC_DET_HIGH, // 2 timer 0
    IPWC_DET_BOTH, // 1 radio
    IPWC_DET_FALL // 0 P0.3
  };

  function automatic logic [15:0] vec_of(input ipwc_src_t idx);
    case (idx)
      4'd0: vec_of = `IPWC_VEC_P03;
      4'd1: vec_of = `IPWC_VEC_RADIO;
      4'd2: vec_of = `IPWC_VEC_TIMER0;
      4'd3: vec_of = `IPWC_VEC_RADIO_SPI;
      4'd4: vec_of = `IPWC_VEC_P04;
      4'd5: vec_of = `IPWC_VEC_SPI;
      4'd6: vec_of = `IPWC_VEC_TIMER1;
      4'd7: vec_of = `IPWC_VEC_USB_WAKE;
      4'd8, 4'd9: vec_of = `IPWC_VEC_SERIAL;
      4'd10: vec_of = `IPWC_VEC_USB;
      4'd11, 4'd12: vec_of = `IPWC_VEC_TIMER2;
      4'd13: vec_of = `IPWC_VEC_WAKE;
      4'd14: vec_of = `IPWC_VEC_CRYPTO;
      default: vec_of = 16'h0000;
    endcase
  endfunction

  // Priority group; crypto has none and sits below all groups
  function automatic logic [2:0] grp_of(input ipwc_src_t idx);
    case (idx)
      4'd0, 4'd1: grp_of = 3'd0;
      4'd2, 4'd3: grp_of = 3'd1;
      4'd4, 4'd5: grp_of = 3'd2;
      4'd6, 4'd7: grp_of = 3'd3;
      4'd8, 4'd9, 4'd10: grp_of = 3'd4;
      4'd11, 4'd12, 4'd13: grp_of = 3'd5;
      default: grp_of = 3'd6;
    endcase
  endfunction

  // Request flag bits that hardware clears when the routine is vectored
  function automatic logic [7:0] autoclr_of(input ipwc_src_t idx);
    case (idx)
      4'd1: autoclr_of = 8'h02;
      4'd5: autoclr_of = 8'h04;
      4'd7: autoclr_of = 8'h08;
      4'd10: autoclr_of = 8'h10;
      4'd13: autoclr_of = 8'h20;
      default: autoclr_of = 8'h00;
    endcase
  endfunction

  function automatic logic wake_ok(input logic [1:0] field,
                                   input logic enable);
    case (ipwc_wake_t'(field))
      IPWC_WAKE_IF_ENABLED: wake_ok = enable;
      IPWC_WAKE_ALWAYS: wake_ok = 1'b1;
      default: wake_ok = 1'b0; // Reserved code is treated as ignore
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [7:0] wakeup_source_config;
  logic [7:0] spi_irq_source_enable;
  logic [7:0] irq_enable_low;
  logic [7:0] priority_bit_low;
  logic [7:0] irq_enable_high;
  logic [7:0] priority_bit_high;
  logic [7:0] irq_request_flags;
  logic [2:0] edge_flags;
  logic [3:0] in_service;
  ipwc_src_t sel_idx;
  ipwc_level_t sel_lvl;

  logic [`IPWC_NUM_LINES-1:0] raw_lines;
  logic [`IPWC_NUM_LINES-1:0] ev;
  logic [`IPWC_NUM_SRC-1:0] pend;
  logic [`IPWC_NUM_SRC-1:0] en;
  logic spi_set;
  logic [7:0] flag_set;
  logic wr_en;
  logic rd_setup;
  logic [9:0] word_addr;
  logic hit;
  logic [7:0] rd_val;
  logic found;
  ipwc_src_t best_idx;
  ipwc_level_t best_lvl;
  logic run_active;
  ipwc_level_t run_lvl;
  logic next_req;
  logic [7:0] next_flags;
  logic [3:0] next_in_service;

  ////////////////////////////////////////////////////////////////////////
  // Request detection

  assign raw_lines = {slave_spi_complete, crypto_ready_request_n,
                      internal_wake_request, timer2_reload_flag,
                      timer2_overflow_flag, usb_request, serial_tx_done,
                      serial_rx_done, usb_wake_request,
                      timer1_overflow_flag, master_spi_complete,
                      p04_pin_n, radio_spi_ready, timer0_overflow_flag,
                      radio_request, p03_pin_n};

  ipwc_edge_detect #(
    .N(`IPWC_NUM_LINES),
    .MODES(DET_MODES)
  ) ipwc_edge_detect_inst (
    .pclk(pclk),
    .presetn(presetn),
    .src_level(raw_lines),
    .src_event(ev)
  );

  // Both completions share one line, each behind its own source bit
  assign spi_set = (ev[5] & spi_irq_source_enable[`IPWC_BIT_SPI_MASTER])
                 | (ev[15] & spi_irq_source_enable[`IPWC_BIT_SPI_SLAVE]);

  // Flags set on radio, radio SPI, USB, USB wake, internal wake, timer 2 and gated SPI events, enabled or not, so waking sources show
  assign flag_set = {ev[12], ev[11], ev[13], ev[10], ev[7], spi_set,
                     ev[1], ev[3]};

  ////////////////////////////////////////////////////////////////////////
  // Pending and enable per source

  assign pend = {edge_flags[2], irq_request_flags[5], irq_request_flags[7],
                 irq_request_flags[6], irq_request_flags[4],
                 serial_tx_done, serial_rx_done, irq_request_flags[3],
                 timer1_overflow_flag, irq_request_flags[2], edge_flags[1],
                 irq_request_flags[0], timer0_overflow_flag,
                 irq_request_flags[1], edge_flags[0]};

  assign en = {1'b1, irq_enable_high[5], irq_enable_high[7],
               irq_enable_low[5], irq_enable_high[4], irq_enable_low[4],
               irq_enable_low[4], irq_enable_high[3], irq_enable_low[3],
               irq_enable_high[2], irq_enable_low[2], irq_enable_high[0],
               irq_enable_low[1], irq_enable_high[1],
               irq_enable_low[0]};

  ////////////////////////////////////////////////////////////////////////
  // Arbitration

  always_comb begin
    logic [2:0] g;
    ipwc_level_t l;
    g = 3'd0;
    l = 2'd0;
    found = 1'b0;
    best_idx = 4'd0;
    best_lvl = 2'd0;
    for (int i = 0; i < `IPWC_NUM_SRC; i++) begin
      g = grp_of(4'(i));
      l = (g < 3'd6) ? {priority_bit_high[g], priority_bit_low[g]}
                     : 2'd0;
      // Strict compare keeps the lowest index among equal levels
      if (pend[i] && en[i] && irq_enable_low[`IPWC_BIT_GLOBAL_EN] &&
          (!found || l > best_lvl)) begin
        found = 1'b1;
        best_idx = 4'(i);
        best_lvl = l;
      end
    end
  end

  always_comb begin
    run_active = |in_service;
    run_lvl = 2'd0;
    for (int k = 0; k < 4; k++) begin
      if (in_service[k]) begin
        run_lvl = 2'(k);
      end
    end
  end

  // Only a strictly higher level pre-empts a running routine
  assign next_req = found && (!run_active || best_lvl > run_lvl) &&
                    !irq_ack;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= next_req;
    end
  end

  // The offered source is frozen in the cycle the core takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_vector <= 16'h0000;
      sel_idx <= 4'd0;
      sel_lvl <= 2'd0;
    end else if (!irq_ack) begin
      irq_vector <= vec_of(best_idx);
      sel_idx <= best_idx;
      sel_lvl <= best_lvl;
    end
  end

  always_comb begin
    next_in_service = in_service;
    if (irq_return) begin
      next_in_service[run_lvl] = 1'b0;
    end
    if (irq_ack && irq_req) begin
      next_in_service[sel_lvl] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_service <= 4'h0;
    end else begin
      in_service <= next_in_service;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin and crypto flags; no register bit, cleared only on vectoring

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_flags <= 3'b000;
    end else begin
      edge_flags[0] <= ev[0] | (edge_flags[0] &
                       ~(irq_ack && irq_req && sel_idx == 4'd0));
      edge_flags[1] <= ev[4] | (edge_flags[1] &
                       ~(irq_ack && irq_req && sel_idx == 4'd4));
      edge_flags[2] <= ev[14] | (edge_flags[2] &
                       ~(irq_ack && irq_req && sel_idx == 4'd14));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave; zero wait states, read data captured in the setup cycle

  assign word_addr = paddr[11:2];
  assign wr_en = psel & penable & pwrite & hit;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    hit = 1'b1;
    rd_val = 8'h00;
    unique case (word_addr)
      {2'b00, `IPWC_IDX_WAKE_CFG}: rd_val = wakeup_source_config;
      {2'b00, `IPWC_IDX_SPI_SRC_EN}: rd_val = spi_irq_source_enable;
      {2'b00, `IPWC_IDX_IEN_LOW}: rd_val = irq_enable_low;
      {2'b00, `IPWC_IDX_PRIO_LOW}: rd_val = priority_bit_low;
      {2'b00, `IPWC_IDX_IEN_HIGH}: rd_val = irq_enable_high;
      {2'b00, `IPWC_IDX_PRIO_HIGH}: rd_val = priority_bit_high;
      {2'b00, `IPWC_IDX_REQ_FLAGS}: rd_val = irq_request_flags;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, rd_val};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_source_config <= `IPWC_RST_WAKE_CFG;
      spi_irq_source_enable <= `IPWC_RST_SPI_SRC_EN;
      irq_enable_low <= `IPWC_RST_IEN;
      priority_bit_low <= `IPWC_RST_PRIO;
      irq_enable_high <= `IPWC_RST_IEN;
      priority_bit_high <= `IPWC_RST_PRIO;
    end else if (wr_en) begin
      unique case (paddr[9:2])
        `IPWC_IDX_WAKE_CFG: wakeup_source_config <= pwdata[7:0];
        `IPWC_IDX_SPI_SRC_EN:
          spi_irq_source_enable <= pwdata[7:0] & `IPWC_MASK_SPI_SRC_EN;
        `IPWC_IDX_IEN_LOW:
          irq_enable_low <= pwdata[7:0] & `IPWC_MASK_IEN;
        `IPWC_IDX_PRIO_LOW:
          priority_bit_low <= pwdata[7:0] & `IPWC_MASK_PRIO;
        `IPWC_IDX_IEN_HIGH:
          irq_enable_high <= pwdata[7:0] & `IPWC_MASK_IEN;
        `IPWC_IDX_PRIO_HIGH:
          priority_bit_high <= pwdata[7:0] & `IPWC_MASK_PRIO;
        default: ;
      endcase
    end
  end

  // A new event wins over both the vectoring clear and a software write
  always_comb begin
    next_flags = irq_request_flags;
    if (irq_ack && irq_req) begin
      next_flags = next_flags & ~autoclr_of(sel_idx);
    end
    if (wr_en && paddr[9:2] == `IPWC_IDX_REQ_FLAGS) begin
      next_flags = pwdata[7:0];
    end
    next_flags = next_flags | flag_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request_flags <= `IPWC_RST_REQ_FLAGS;
    end else begin
      irq_request_flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wakeup gating; only sampled while the core is in standby

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_wake <= 1'b0;
    end else begin
      cpu_wake <= cpu_standby & (
        (ev[1] & wake_ok(wakeup_source_config[7:6], irq_enable_high[1])) |
        (ev[13] & wake_ok(wakeup_source_config[5:4], irq_enable_high[5])) |
        (ev[10] & wake_ok(wakeup_source_config[3:2], irq_enable_high[4])) |
        (ev[7] & wake_ok(wakeup_source_config[1:0], irq_enable_high[3])));
    end
  end

endmodule

// ===== shared/ipwc_params.svh
`ifndef IPWC_PARAMS_SVH
`define IPWC_PARAMS_SVH

// Register indices; the APB byte address is four times the index
`define IPWC_IDX_WAKE_CFG 8'ha5
`define IPWC_IDX_SPI_SRC_EN 8'ha6
`define IPWC_IDX_IEN_LOW 8'ha8
`define IPWC_IDX_PRIO_LOW 8'ha9
`define IPWC_IDX_IEN_HIGH 8'hb8
`define IPWC_IDX_PRIO_HIGH 8'hb9
`define IPWC_IDX_REQ_FLAGS 8'hc0

// Reset values
`define IPWC_RST_WAKE_CFG 8'h00
`define IPWC_RST_SPI_SRC_EN 8'h01
`define IPWC_RST_IEN 8'h00
`define IPWC_RST_PRIO 8'h00
`define IPWC_RST_REQ_FLAGS 8'h00

// Writable bits; the others read as zero
`define IPWC_MASK_SPI_SRC_EN 8'h03
`define IPWC_MASK_IEN 8'hbf
`define IPWC_MASK_PRIO 8'h3f

// Field positions
`define IPWC_BIT_GLOBAL_EN 7
`define IPWC_BIT_SPI_MASTER 1
`define IPWC_BIT_SPI_SLAVE 0

// Vector addresses
`define IPWC_VEC_P03 16'h0003
`define IPWC_VEC_TIMER0 16'h000b
`define IPWC_VEC_CRYPTO 16'h0013
`define IPWC_VEC_TIMER1 16'h001b
`define IPWC_VEC_SERIAL 16'h0023
`define IPWC_VEC_TIMER2 16'h002b
`define IPWC_VEC_P04 16'h0033
`define IPWC_VEC_RADIO_SPI 16'h0043
`define IPWC_VEC_RADIO 16'h004b
`define IPWC_VEC_SPI 16'h0053
`define IPWC_VEC_USB_WAKE 16'h005b
`define IPWC_VEC_USB 16'h0063
`define IPWC_VEC_WAKE 16'h006b

`define IPWC_NUM_SRC 15
`define IPWC_NUM_LINES 16

`endif

// ===== shared/ipwc_pkg.sv
package ipwc_pkg;

  typedef enum logic [1:0] {
    IPWC_DET_HIGH = 2'b00,
    IPWC_DET_FALL = 2'b01,
    IPWC_DET_RISE = 2'b10,
    IPWC_DET_BOTH = 2'b11
  } ipwc_detect_t;

  typedef enum logic [1:0] {
    IPWC_WAKE_IF_ENABLED = 2'b00,
    IPWC_WAKE_RESERVED = 2'b01,
    IPWC_WAKE_ALWAYS = 2'b10,
    IPWC_WAKE_IGNORE = 2'b11
  } ipwc_wake_t;

  typedef logic [1:0] ipwc_level_t;
  typedef logic [3:0] ipwc_src_t;

endpackage

// ===== rtl/ipwc_edge_detect.sv
`timescale 1ns/1ns
module ipwc_edge_detect
  import ipwc_pkg::*;
#(
  parameter int N = 16,
  parameter logic [2*N-1:0] MODES = '0
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic [N-1:0] src_level, // Raw request lines
  output logic [N-1:0] src_event // Detected request, one per line
);

  logic [N-1:0] prev;

  // Previous sample; reset low so a falling line cannot fire at start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= '0;
    end else begin
      prev <= src_level;
    end
  end

  always_comb begin
    src_event = '0;
    for (int i = 0; i < N; i++) begin
      unique case (ipwc_detect_t'(MODES[2*i +: 2]))
        IPWC_DET_HIGH: src_event[i] = src_level[i];
        IPWC_DET_FALL: src_event[i] = prev[i] & ~src_level[i];
        IPWC_DET_RISE: src_event[i] = ~prev[i] & src_level[i];
        IPWC_DET_BOTH: src_event[i] = prev[i] ^ src_level[i];
      endcase
    end
  end

endmodule

// ===== testbench/ipwc_irq_ctrl_props.sv
`timescale 1ns/1ns
module ipwc_irq_ctrl_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pslverr, // APB error
  input wire logic irq_req, // Request to core
  input wire logic [15:0] irq_vector, // Offered vector
  input wire logic irq_ack, // Core takes request
  input wire logic cpu_standby, // Core clock stopped
  input wire logic cpu_wake, // Wake pulse
  input wire logic usb_wake_request // USB wake line
);
  default clocking dck @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ge;
  logic [7:0] wcfg;
  logic wr;
  logic map;
  assign wr = psel && penable && pwrite;
  assign map = paddr[11:2] inside {10'h0a5, 10'h0a6, 10'h0a8, 10'h0a9,
                                   10'h0b8, 10'h0b9, 10'h0c0};
  // Shadows of the global gate and wake fields, taken from bus writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ge <= 1'b0;
      wcfg <= 8'h00;
    end else begin
      if (wr && paddr == 12'h2a0) ge <= pwdata[7];
      if (wr && paddr == 12'h294) wcfg <= pwdata[7:0];
    end
  end
////////////////////////////////////////////////////////////
  a_err_unmapped:
    assert property (psel && penable && paddr[1:0] == 2'b00
      |-> pslverr == !map) else $error("pslverr wrong for address");
  a_unmapped_rd_zero:
    assert property (psel && penable && !pwrite && !map
      |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_upper_zero:
    assert property (prdata[31:8] == 24'h0) else $error("prdata upper set");
  a_ack_drops_req:
    assert property (irq_req && irq_ack |=> !irq_req)
      else $error("request stays after ack");
  a_vector_known:
    assert property (irq_req |-> irq_vector inside {16'h0003, 16'h000b,
      16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0033, 16'h0043,
      16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b})
      else $error("unknown vector offered");
  a_gate_blocks:
    assert property (!ge && !$past(ge) |-> !irq_req)
      else $error("request while globally disabled");
  a_wake_standby:
    assert property (cpu_wake |-> $past(cpu_standby))
      else $error("wake without standby");
  a_wake_always:
    assert property (cpu_standby && wcfg[1:0] == 2'b10
      && $rose(usb_wake_request) |-> ##[1:2] cpu_wake)
      else $error("forced wake missing");
  a_wake_ignore:
    assert property (wcfg == 8'hff && $past(wcfg) == 8'hff |-> !cpu_wake)
      else $error("wake while all ignored");
  c_taken: cover property (irq_req && irq_ack);
  c_wake: cover property (cpu_wake);
  c_err: cover property (psel && penable && pslverr);
endmodule
bind ipwc_irq_ctrl ipwc_irq_ctrl_props ipwc_irq_ctrl_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .irq_req(irq_req), .irq_vector(irq_vector),
  .irq_ack(irq_ack), .cpu_standby(cpu_standby), .cpu_wake(cpu_wake),
  .usb_wake_request(usb_wake_request));

// ===== testbench/ipwc_core_model.sv
`timescale 1ns/1ns
module ipwc_core_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic irq_req, // Offered request
  input wire logic [15:0] irq_vector, // Offered vector
  input wire logic hold, // Core masks requests, answers late
  input wire logic ret, // Leave the running routine
  output logic irq_ack, // Take pulse
  output logic irq_return, // Return pulse
  output logic [15:0] last_vec, // Vector of last taken request
  output logic [7:0] taken // Count of taken requests
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      last_vec <= 16'h0000;
      taken <= 8'h00;
    end else begin
      // Never acks twice in a row: the request must drop after a take
      irq_ack <= irq_req && !irq_ack && !hold;
      irq_return <= ret;
      if (irq_req && irq_ack) begin
        last_vec <= irq_vector;
        taken <= taken + 8'h01;
      end
    end
  end
endmodule

// ===== testbench/irq_priority_wakeup_ctrl_test.sv
`timescale 1ns/1ns
module irq_priority_wakeup_ctrl_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic irq_req, irq_ack, irq_return, cpu_standby, cpu_wake, hold, ret;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [15:0] s, irq_vector, lv;
  logic [7:0] taken, c0;
  int fail_count, checked, wcnt, w0;
  localparam logic [15:0] vec_tab [16] = '{16'h0003, 16'h000b, 16'h0013,
    16'h001b, 16'h0023, 16'h0023, 16'h002b, 16'h002b, 16'h0043, 16'h004b,
    16'h0053, 16'h0053, 16'h005b, 16'h0063, 16'h006b, 16'h0033};
  localparam logic [7:0] ix [6] = '{8'ha5, 8'ha6, 8'ha8, 8'ha9, 8'hb8, 8'hb9};
  localparam logic [7:0] rv [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] mk [6] = '{8'hff, 8'h03, 8'hbf, 8'h3f, 8'hbf, 8'h3f};
  ipwc_irq_ctrl ipwc_irq_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .p03_pin_n(~s[0]), .p04_pin_n(~s[15]), .crypto_ready_request_n(~s[2]),
    .timer0_overflow_flag(s[1]), .timer1_overflow_flag(s[3]),
    .timer2_overflow_flag(s[6]), .timer2_reload_flag(s[7]),
    .serial_rx_done(s[4]), .serial_tx_done(s[5]), .radio_spi_ready(s[8]),
    .radio_request(s[9]), .master_spi_complete(s[10]),
    .slave_spi_complete(s[11]), .usb_request(s[13]),
    .usb_wake_request(s[12]), .internal_wake_request(s[14]),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .irq_return(irq_return), .cpu_standby(cpu_standby), .cpu_wake(cpu_wake));
  ipwc_core_model ipwc_core_model_inst (.pclk(pclk), .presetn(presetn),
    .irq_req(irq_req), .irq_vector(irq_vector), .hold(hold), .ret(ret),
    .irq_ack(irq_ack), .irq_return(irq_return), .last_vec(lv),
    .taken(taken));
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (cpu_wake === 1'b1) wcnt <= wcnt + 1;
////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic [7:0] x, input logic w, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, x, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) fail_count++;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] x, input logic [7:0] d);
    apb(x, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] x);
    apb(x, 1'b0, 8'h00);
  endtask
  // Caller snapshots c0 before the trigger, so a fast take is not missed
  task automatic wt();
    int n;
    n = 0;
    while (taken === c0 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk({24'h0, taken}, {24'h0, c0 + 8'h01});
  endtask
  task automatic do_ret();
    ret <= 1'b1;
    @(posedge pclk);
    ret <= 1'b0;
    @(posedge pclk);
  endtask
////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int j = 0; j < 6; j++) begin
      rd(ix[j]);
      chk(rq, {24'h0, rv[j]});
      wr(ix[j], 8'hff);
      rd(ix[j]);
      chk(rq, {24'h0, mk[j]});
      wr(ix[j], rv[j]);
    end
    rd(8'hc0);
    chk(rq, 32'h0);
    rd(8'ha7);
    chk({31'h0, re}, 32'h1);
    chk(rq, 32'h0);
    $display("registers done");
  endtask
  task automatic t_vectors();
    wr(8'ha8, 8'hbf);
    wr(8'hb8, 8'hbf);
    wr(8'ha6, 8'h03);
    for (int i = 0; i < 16; i++) begin
      hold <= 1'b0;
      c0 = taken;
      s[i] <= 1'b1;
      wt();
      chk({16'h0, lv}, {16'h0, vec_tab[i]});
      hold <= 1'b1;
      rd(8'hc0);
      chk(rq, i==6 ? 32'h40 : i==7 ? 32'h80 : i==8 ? 32'h1 : 32'h0);
      s[i] <= 1'b0;
      cyc(4);
      wr(8'hc0, 8'h00);
      do_ret();
    end
    $display("vectors done");
  endtask
  task automatic pair(input int a, input int b, input logic [7:0] p,
                      input logic [15:0] ev);
    wr(8'hb9, p);
    wr(8'ha9, p);
    hold <= 1'b1;
    s[a] <= 1'b1;
    s[b] <= 1'b1;
    cyc(3);
    c0 = taken;
    hold <= 1'b0;
    wt();
    chk({16'h0, lv}, {16'h0, ev});
    cyc(6);
    chk({24'h0, taken}, {24'h0, c0 + 8'h01});
    hold <= 1'b1;
    s[a] <= 1'b0;
    s[b] <= 1'b0;
    cyc(4);
    wr(8'hc0, 8'h00);
    do_ret();
  endtask
  task automatic t_gate();
    hold <= 1'b0;
    wr(8'ha8, 8'h3f);
    wr(8'hb8, 8'h10);
    c0 = taken;
    s[13] <= 1'b1;
    cyc(6);
    chk({31'h0, irq_req}, 32'h0);
    chk({24'h0, taken}, {24'h0, c0});
    rd(8'hc0);
    chk(rq, 32'h10);
    c0 = taken;
    wr(8'ha8, 8'hbf);
    wt();
    chk({16'h0, lv}, 32'h0063);
    s[13] <= 1'b0;
    do_ret();
    $display("gate done");
  endtask
  task automatic wk(input logic [7:0] cfg, input logic [7:0] eh, input int src,
                    input logic [31:0] ew, input logic [7:0] fl);
    wr(8'hc0, 8'h00);
    wr(8'ha5, cfg);
    wr(8'hb8, eh);
    w0 = wcnt;
    s[src] <= 1'b1;
    cyc(4);
    chk(32'(wcnt - w0), ew);
    rd(8'hc0);
    chk(rq, {24'h0, fl});
    s[src] <= 1'b0;
    cyc(4);
  endtask
  task automatic t_spi();
    wr(8'hc0, 8'h00);
    wr(8'ha6, 8'h01);
    s[10] <= 1'b1;
    cyc(4);
    rd(8'hc0);
    chk(rq, 32'h0);
    s[10] <= 1'b0;
    s[11] <= 1'b1;
    cyc(4);
    rd(8'hc0);
    chk(rq, 32'h04);
    s[11] <= 1'b0;
    cyc(4);
    wr(8'hc0, 8'h00);
    $display("spi done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite, hold, ret, cpu_standby} = '0;
    paddr = '0;
    pwdata = '0;
    s = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_vectors();
    pair(3, 12, 8'h00, 16'h001b);
    pair(13, 1, 8'h00, 16'h000b);
    pair(1, 13, 8'h10, 16'h0063);
    $display("priority done");
    t_gate();
    wr(8'ha8, 8'h00);
    cpu_standby <= 1'b1;
    wk(8'h02, 8'h00, 12, 32'h1, 8'h08);
    wk(8'hff, 8'h10, 13, 32'h0, 8'h10);
    wk(8'h00, 8'h00, 9, 32'h0, 8'h02);
    wk(8'h00, 8'h02, 9, 32'h1, 8'h02);
    wk(8'h01, 8'h08, 12, 32'h0, 8'h08);
    cpu_standby <= 1'b0;
    $display("wake done");
    t_spi();
    complete_run();
  end
  // The whole run needs about 600 cycles
  initial begin
    repeat (8000) @(posedge pclk);
    fail_count++;
    complete_run();
  end
endmodule
